//--- jog_feed_pkg.sv
package jog_feed_pkg;

  // ---------------------------------------------------------------
  // geometry
  // ---------------------------------------------------------------
  localparam int NUM_AXES = 8;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_MODE     = 8'h00;
  localparam logic [7:0] OFS_REQUEST  = 8'h04;
  localparam logic [7:0] OFS_OVERRIDE = 8'h08;
  localparam logic [7:0] OFS_LOCK     = 8'h0C;
  localparam logic [7:0] OFS_CONFIG   = 8'h10;
  localparam logic [7:0] OFS_AXIS_CFG = 8'h14;
  localparam logic [7:0] OFS_POS_ERR  = 8'h18;
  localparam logic [7:0] OFS_INPOS_W  = 8'h1C;
  localparam logic [7:0] OFS_STATUS   = 8'h20;
  localparam logic [7:0] OFS_MOTION   = 8'h24;
  localparam logic [7:0] OFS_RATE     = 8'h28;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int MODE_LOWER_BIT     = 0;
  localparam int MODE_MIDDLE_BIT    = 1;
  localparam int MODE_UPPER_BIT     = 2;
  localparam int REQ_MINUS_POS      = 8;
  localparam int LOCK_AXIS_POS      = 8;
  localparam int LOCK_GLOBAL_BIT    = 0;
  localparam int CFG_GLOBAL_DIS_BIT = 0;
  localparam int CFG_AXIS_DIS_BIT   = 2;
  localparam int CFG_PER_REV_BIT    = 3;
  localparam int CFG_CNC_RESET_BIT  = 8;
  localparam int CFG_SERVO_BIT      = 9;
  localparam int CFG_SPINDLE_BIT    = 10;
  localparam int ST_JOG_MODE_BIT    = 0;
  localparam int ST_OVR_ZERO_BIT    = 1;
  localparam int ST_PER_REV_BIT     = 2;
  localparam int ST_INPOS_POS       = 8;

  // ---------------------------------------------------------------
  // codes and reset values
  // ---------------------------------------------------------------
  localparam logic [2:0]  JOG_MODE_CODE   = 3'h5;
  localparam logic [15:0] OVR_ALL_ONES    = 16'hFFFF;
  localparam logic [15:0] OVR_ALL_ZEROS   = 16'h0000;
  localparam logic [15:0] OVR_RESET       = 16'hFFFF;
  localparam logic [7:0]  LOCK_RESET      = 8'h01;
  localparam logic [15:0] CFG_RESET       = 16'h0100;
  localparam logic [15:0] INPOS_W_RESET   = 16'h0014;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

endpackage

//--- jog_axis_gate.sv
module jog_axis_gate (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        jog_mode,
  input  wire logic        plus_req,
  input  wire logic        minus_req,
  input  wire logic        allowed,
  output logic             move_plus,
  output logic             move_minus
);

  logic plus_prev;
  logic minus_prev;
  logic plus_arm;
  logic minus_arm;

  // ---------------------------------------------------------------
  // edge arming
  // ---------------------------------------------------------------
  // previous value taken as high outside jog so a held key never arms
  wire plus_rise  = plus_req & ~plus_prev;
  wire minus_rise = minus_req & ~minus_prev;
  wire next_plus_arm  = jog_mode & plus_req & (plus_arm | plus_rise);
  wire next_minus_arm = jog_mode & minus_req & (minus_arm | minus_rise);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      plus_prev  <= 1'b1;
      minus_prev <= 1'b1;
      plus_arm   <= 1'b0;
      minus_arm  <= 1'b0;
    end else if (ce) begin
      plus_prev  <= plus_req | ~jog_mode;
      minus_prev <= minus_req | ~jog_mode;
      plus_arm   <= next_plus_arm;
      minus_arm  <= next_minus_arm;
    end
  end

  // both directions at once cancel; leaving jog stops motion at once
  assign move_plus  = plus_arm & ~minus_arm & allowed & jog_mode;
  assign move_minus = minus_arm & ~plus_arm & allowed & jog_mode;

endmodule

//--- jog_feed_gating.sv
// Notes on behaviour
// - jog mode only for code 1,0,1
// - direction bits high request axis jog
// - motion starts on request rising edge only
// - flag pending while position error exceeds width
// - override inverted; all ones/zeros mean 0%
// - override is inverse, 0.01% per count
// - global lock used while its disable is 0
// - axis locks used while their disable is 0
// - global lock low inhibits motion
// - axis lock low inhibits that axis
// - controller reset blocks manual and automatic
// - feed basis bit: 0 per-minute, 1 per-rev
// - per-rev feed needs spindle turning
// - index axis refuses all manual feed
// - servo inactive inhibits all motion
module jog_feed_gating #(
  parameter int NUM_AXES = jog_feed_pkg::NUM_AXES
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  output logic [NUM_AXES-1:0]        jog_plus,
  output logic [NUM_AXES-1:0]        jog_minus,
  output logic [15:0]                jog_rate_pct,
  output logic                       jog_per_rev,
  output logic                       auto_enable
);
  import jog_feed_pkg::*;

  // ---------------------------------------------------------------
  // software-written registers
  // ---------------------------------------------------------------
  logic [2:0]          mode_code;
  logic [NUM_AXES-1:0] axis_plus_request;
  logic [NUM_AXES-1:0] axis_minus_request;
  logic [15:0]         jog_override_inverted;
  logic                global_lock_n;
  logic [NUM_AXES-1:0] axis_lock_n;
  logic [15:0]         config_bits;
  logic [NUM_AXES-1:0] index_axis;
  logic [15:0]         position_error_diag;
  logic [15:0]         inpos_width;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  wire mode_code_upper  = mode_code[MODE_UPPER_BIT];
  wire mode_code_middle = mode_code[MODE_MIDDLE_BIT];
  wire mode_code_lower  = mode_code[MODE_LOWER_BIT];
  wire jog_mode = ({mode_code_upper, mode_code_middle, mode_code_lower} == JOG_MODE_CODE);

  wire global_lock_disable = config_bits[CFG_GLOBAL_DIS_BIT];
  wire axis_lock_disable   = config_bits[CFG_AXIS_DIS_BIT];
  wire per_rev_feed_select = config_bits[CFG_PER_REV_BIT];
  wire cnc_reset           = config_bits[CFG_CNC_RESET_BIT];
  wire servo_active        = config_bits[CFG_SERVO_BIT];
  wire spindle_turning     = config_bits[CFG_SPINDLE_BIT];

  wire [15:0] override_pct = ~jog_override_inverted;
  wire override_zero = (jog_override_inverted == OVR_ALL_ONES) ||
                       (jog_override_inverted == OVR_ALL_ZEROS);
  wire [15:0] next_rate = override_zero ? 16'h0000 : override_pct;

  wire global_inhibit = ~global_lock_disable & ~global_lock_n;
  wire [NUM_AXES-1:0] axis_inhibit =
    {NUM_AXES{~axis_lock_disable}} & ~axis_lock_n;
  wire feed_basis_ok = ~per_rev_feed_select | spindle_turning;
  wire common_ok = ~override_zero & ~global_inhibit & servo_active &
                   ~cnc_reset & feed_basis_ok;

  wire [NUM_AXES-1:0] inpos_pending =
    {NUM_AXES{position_error_diag > inpos_width}};

  // ---------------------------------------------------------------
  // per-axis gates
  // ---------------------------------------------------------------
  wire [NUM_AXES-1:0] next_plus;
  wire [NUM_AXES-1:0] next_minus;
  wire [NUM_AXES-1:0] axis_ok = ~axis_inhibit & ~index_axis;

  genvar g;
  generate
    for (g = 0; g < NUM_AXES; g++) begin : g_axis
      jog_axis_gate u_gate (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .ce         (ce),
        .jog_mode   (jog_mode),
        .plus_req   (axis_plus_request[g]),
        .minus_req  (axis_minus_request[g]),
        .allowed    (common_ok & axis_ok[g]),
        .move_plus  (next_plus[g]),
        .move_minus (next_minus[g])
      );
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      jog_plus     <= '0;
      jog_minus    <= '0;
      jog_rate_pct <= 16'h0000;
      jog_per_rev  <= 1'b0;
      auto_enable  <= 1'b0;
    end else if (ce) begin
      jog_plus     <= next_plus;
      jog_minus    <= next_minus;
      jog_rate_pct <= next_rate;
      jog_per_rev  <= per_rev_feed_select;
      auto_enable  <= ~cnc_reset & servo_active;
    end
  end

  // ---------------------------------------------------------------
  // axi4-lite slave
  // ---------------------------------------------------------------
  // one write and one read in flight; address and data in either order
  logic       aw_held;
  logic       w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take  = s_axi_wvalid & s_axi_wready;
  wire wr_go   = aw_held & w_held & ~s_axi_bvalid;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic known(input logic [7:0] a);
    known = (a[1:0] == 2'b00) && (a <= OFS_RATE);
  endfunction

  wire [15:0] req_old = {8'h00, axis_plus_request} |
                        ({8'h00, axis_minus_request} << REQ_MINUS_POS);
  wire [15:0] lock_old = {8'h00, 7'h00, global_lock_n} |
                         ({8'h00, axis_lock_n} << LOCK_AXIS_POS);
  wire [15:0] req_new  = merge16(req_old, w_data, w_strb);
  wire [15:0] lock_new = merge16(lock_old, w_data, w_strb);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= 8'h00;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else if (ce) begin
      if (aw_take) begin
        aw_held       <= 1'b1;
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= known(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // status and read-only words ignore writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_code             <= 3'h0;
      axis_plus_request     <= '0;
      axis_minus_request    <= '0;
      jog_override_inverted <= OVR_RESET;
      global_lock_n         <= LOCK_RESET[0];
      axis_lock_n           <= '1;
      config_bits           <= CFG_RESET;
      index_axis            <= '0;
      position_error_diag   <= 16'h0000;
      inpos_width           <= INPOS_W_RESET;
    end else if (ce && wr_go) begin
      case (aw_addr)
        OFS_MODE: mode_code <= w_strb[0] ?
                               w_data[2:0] : mode_code;
        OFS_REQUEST: begin
          axis_plus_request  <= req_new[NUM_AXES-1:0];
          axis_minus_request <= req_new[REQ_MINUS_POS +: NUM_AXES];
        end
        OFS_OVERRIDE: jog_override_inverted <= merge16(jog_override_inverted, w_data, w_strb);
        OFS_LOCK: begin
          global_lock_n <= lock_new[LOCK_GLOBAL_BIT];
          axis_lock_n   <= lock_new[LOCK_AXIS_POS +: NUM_AXES];
        end
        OFS_CONFIG:   config_bits <= merge16(config_bits, w_data, w_strb);
        OFS_AXIS_CFG: index_axis <= w_strb[0] ? w_data[NUM_AXES-1:0] : index_axis;
        OFS_POS_ERR:  position_error_diag <= merge16(position_error_diag, w_data, w_strb);
        OFS_INPOS_W:  inpos_width <= merge16(inpos_width, w_data, w_strb);
        default: ;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  wire [15:0] status_word = {inpos_pending, 5'h00, per_rev_feed_select,
                             override_zero, jog_mode};
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      OFS_MODE:     rd_mux = {29'h0000_0000, mode_code};
      OFS_REQUEST:  rd_mux = {16'h0000, req_old};
      OFS_OVERRIDE: rd_mux = {16'h0000, jog_override_inverted};
      OFS_LOCK:     rd_mux = {16'h0000, lock_old};
      OFS_CONFIG:   rd_mux = {16'h0000, config_bits};
      OFS_AXIS_CFG: rd_mux = {24'h00_0000, index_axis};
      OFS_POS_ERR:  rd_mux = {16'h0000, position_error_diag};
      OFS_INPOS_W:  rd_mux = {16'h0000, inpos_width};
      OFS_STATUS:   rd_mux = {16'h0000, status_word};
      OFS_MOTION:   rd_mux = {16'h0000, jog_minus, jog_plus};
      OFS_RATE:     rd_mux = {16'h0000, jog_rate_pct};
      default:      rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_mode_gate;
    @(posedge aclk) disable iff (!aresetn)
      ce && !jog_mode |=> (jog_plus == '0) && (jog_minus == '0);
  endproperty
  a_mode_gate: assert property (p_mode_gate) else $error("jog outside jog mode");

  property p_held_request;
    @(posedge aclk) disable iff (!aresetn)
      ce && !jog_mode && axis_plus_request[0] ##1 ce && jog_mode && axis_plus_request[0] ##1 ce
        |=> !jog_plus[0];
  endproperty
  a_held_request: assert property (p_held_request) else $error("held request moved axis");

  property p_override_zero;
    @(posedge aclk) disable iff (!aresetn)
      ce && override_zero |=> jog_rate_pct == 16'h0000;
  endproperty
  a_override_zero: assert property (p_override_zero) else $error("zero override nonzero rate");

  property p_override_val;
    @(posedge aclk) disable iff (!aresetn)
      ce && !override_zero |=> jog_rate_pct == ~$past(jog_override_inverted);
  endproperty
  a_override_val: assert property (p_override_val) else $error("override not inverse");

  property p_global_lock;
    @(posedge aclk) disable iff (!aresetn)
      ce && !global_lock_disable && !global_lock_n |=> jog_plus == '0;
  endproperty
  a_global_lock: assert property (p_global_lock) else $error("global lock ignored");

  property p_axis_lock;
    @(posedge aclk) disable iff (!aresetn)
      ce && !axis_lock_disable && !axis_lock_n[0] |=> !jog_minus[0];
  endproperty
  a_axis_lock: assert property (p_axis_lock) else $error("axis lock ignored");

  property p_reset_block;
    @(posedge aclk) disable iff (!aresetn)
      ce && cnc_reset |=> !auto_enable && jog_plus == '0;
  endproperty
  a_reset_block: assert property (p_reset_block) else $error("reset state not blocking");

  property p_per_rev;
    @(posedge aclk) disable iff (!aresetn)
      ce && per_rev_feed_select && !spindle_turning |=> jog_minus == '0;
  endproperty
  a_per_rev: assert property (p_per_rev) else $error("per-rev moved w/o spindle");

  property p_index_axis;
    @(posedge aclk) disable iff (!aresetn)
      ce && index_axis[1] |=> !jog_plus[1] && !jog_minus[1];
  endproperty
  a_index_axis: assert property (p_index_axis) else $error("index axis moved");

  property p_servo;
    @(posedge aclk) disable iff (!aresetn)
      ce && !servo_active |=> !auto_enable && jog_plus == '0;
  endproperty
  a_servo: assert property (p_servo) else $error("servo off but motion");

  c_jog_move: cover property (@(posedge aclk) disable iff (!aresetn) jog_plus[0]);
  c_write:    cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid);
  c_read:     cover property (@(posedge aclk) disable iff (!aresetn) s_axi_rvalid);

endmodule

//--- ladder_master.sv
// ---------------------------------------------
// bus side of the ladder controller
// ---------------------------------------------
module ladder_master (
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0000_0000;
    wstrb = 4'hf;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end
  // released payload is inverted so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_on;
    logic w_on;
    logic wait_b;
    aw_on = 1'b1;
    w_on = 1'b1;
    wait_b = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (wait_b) begin
      @(posedge aclk);
      if (aw_on && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
        aw_on = 1'b0;
      end
      if (w_on && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
        w_on = 1'b0;
      end
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        wait_b = 1'b0;
      end
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic wait_r;
    wait_r = 1'b1;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (wait_r) begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        wait_r = 1'b0;
      end
    end
  endtask
endmodule

//--- test_jog_feed_gating.sv
module test_jog_feed_gating;
  timeunit 1ns;
  timeprecision 1ns;
  import jog_feed_pkg::*;
  // ---------------------------------------------
  // signals and reference state
  // ---------------------------------------------
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  awaddr, araddr, jog_plus, jog_minus, arm_p = 8'h00, arm_m = 8'h00;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic [15:0] jog_rate_pct;
  logic        jog_per_rev, auto_enable;
  int          fail_count = 0;
  int          comparisons = 0;
  int          cycles = 0;
  logic [31:0] m_mode = 32'h0000_0000, m_req = 32'h0000_0000, m_ovr = 32'h0000_ffff, m_lock = 32'h0000_ff01;
  logic [31:0] m_cfg = 32'h0000_0100, m_idx = 32'h0000_0000, m_perr = 32'h0000_0000, m_wid = 32'h0000_0014;
  logic [15:0] ovr_tab [5] = '{16'hffff, 16'hfffe, 16'hd8ef, 16'h0001, 16'h0000};
  logic [7:0]  p_addr [11] = '{OFS_LOCK, OFS_CONFIG, OFS_LOCK, OFS_CONFIG, OFS_CONFIG, OFS_CONFIG,
                              OFS_CONFIG, OFS_CONFIG, OFS_AXIS_CFG, OFS_OVERRIDE, OFS_MODE};
  logic [31:0] p_data [11] = '{32'h0000_ff00, 32'h0000_0201, 32'h0000_0001, 32'h0000_0205, 32'h0000_0305,
                              32'h0000_0005, 32'h0000_020d, 32'h0000_060d, 32'h0000_0000, 32'h0000_ffff,
                              32'h0000_0001};
  always #20 aclk = ~aclk;
  jog_feed_gating dut_u (.aclk, .aresetn, .ce, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .jog_plus, .jog_minus,
    .jog_rate_pct, .jog_per_rev, .auto_enable);
  ladder_master ladder_u (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  // ---------------------------------------------
  // checking helpers
  // ---------------------------------------------
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      fail_count++;
      $display("MISMATCH t=%0t timeout", $time);
      finish_test();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [15:0] rate_exp();
    return (m_ovr[15:0] == 16'hffff || m_ovr[15:0] == 16'h0000) ? 16'h0000 : ~m_ovr[15:0];
  endfunction
  function automatic logic [31:0] st_exp();
    return {16'h0000, (m_perr[15:0] > m_wid[15:0]) ? 8'hff : 8'h00, 5'h00, m_cfg[3], rate_exp() == 16'h0000,
            m_mode[2:0] == JOG_MODE_CODE};
  endfunction
  // arming is kept apart from permissives: a lock only masks motion
  function automatic logic [7:0] ok_axes();
    logic [7:0] k;
    for (int n = 0; n < 8; n++) begin
      k[n] = (m_cfg[2] | m_lock[LOCK_AXIS_POS + n]) & ~m_idx[n];
    end
    if (m_mode[2:0] != JOG_MODE_CODE || rate_exp() == 16'h0000 || !(m_cfg[0] | m_lock[0]) || m_cfg[8]
        || !m_cfg[9] || (m_cfg[3] && !m_cfg[10])) begin
      k = 8'h00;
    end
    return k;
  endfunction
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    logic       jm;
    jm = m_mode[2:0] == JOG_MODE_CODE;
    ladder_u.wr(a, d, r);
    cmp(32'(r), 32'(RESP_OKAY), "bresp");
    case (a)
      OFS_MODE: m_mode = d;
      OFS_REQUEST: begin
        arm_p = (arm_p | (jm ? d[7:0] & ~m_req[7:0] : 8'h00)) & d[7:0];
        arm_m = (arm_m | (jm ? d[15:8] & ~m_req[15:8] : 8'h00)) & d[15:8];
        m_req = d;
      end
      OFS_OVERRIDE: m_ovr = d;
      OFS_LOCK: m_lock = d;
      OFS_CONFIG: m_cfg = d;
      OFS_AXIS_CFG: m_idx = d;
      OFS_POS_ERR: m_perr = d;
      OFS_INPOS_W: m_wid = d;
      default: ;
    endcase
    if (m_mode[2:0] != JOG_MODE_CODE) begin
      arm_p = 8'h00;
      arm_m = 8'h00;
    end
  endtask
  task automatic chk_motion();
    logic [7:0]  ep, em;
    logic [31:0] d;
    logic [1:0]  r;
    repeat (4) @(posedge aclk);
    #1;
    ep = arm_p & ~arm_m & ok_axes();
    em = arm_m & ~arm_p & ok_axes();
    cmp(32'(jog_plus), 32'(ep), "plus");
    cmp(32'(jog_minus), 32'(em), "minus");
    cmp(32'(jog_rate_pct), 32'(rate_exp()), "rate");
    cmp(32'(jog_per_rev), 32'(m_cfg[3]), "per rev");
    cmp(32'(auto_enable), 32'(!m_cfg[8] && m_cfg[9]), "auto");
    ladder_u.rd(OFS_MOTION, d, r);
    cmp(d, {16'h0000, em, ep}, "motion reg");
  endtask
  task automatic chk_status();
    logic [31:0] d;
    logic [1:0]  r;
    ladder_u.rd(OFS_STATUS, d, r);
    cmp(d, st_exp(), "status");
  endtask
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    void'($urandom(32'h2073_bdab));
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    ladder_u.rd(OFS_OVERRIDE, d, r);
    cmp(d, 32'h0000_ffff, "ovr reset");
    ladder_u.rd(OFS_CONFIG, d, r);
    cmp(d, 32'h0000_0100, "cfg reset");
    ladder_u.rd(OFS_INPOS_W, d, r);
    cmp(d, 32'h0000_0014, "width reset");
    chk_motion();
    ladder_u.rd(8'h2c, d, r);
    cmp({30'h0000_0000, r}, 32'(RESP_SLVERR), "rd unmapped");
    cmp(d, 32'h0000_0000, "rd unmapped data");
    ladder_u.wr(8'h2c, 32'h1234_5678, r);
    cmp({30'h0000_0000, r}, 32'(RESP_SLVERR), "wr unmapped");
    $display("test reset and map done");
    for (int c = 0; c < 8; c++) begin
      w(OFS_MODE, 32'(c));
      chk_status();
    end
    w(OFS_CONFIG, 32'h0000_0200);
    w(OFS_LOCK, 32'h0000_ff01);
    for (int i = 0; i < 6; i++) begin
      d = (i < 5) ? {16'h0000, ovr_tab[i]} : $urandom;
      w(OFS_OVERRIDE, d);
      chk_motion();
      chk_status();
    end
    $display("test mode and override done");
    n = $urandom % 8;
    w(OFS_OVERRIDE, 32'h0000_d8ef);
    w(OFS_MODE, 32'h0000_0000);
    w(OFS_REQUEST, 32'h0000_0001 << n);
    w(OFS_MODE, 32'h0000_0005);
    chk_motion();
    w(OFS_REQUEST, 32'h0000_0000);
    w(OFS_REQUEST, 32'h0000_0001 << n);
    ce <= 1'b0;
    repeat (4) @(posedge aclk);
    #1;
    cmp(32'(jog_plus), 32'h0000_0000, "frozen");
    @(posedge aclk);
    ce <= 1'b1;
    chk_motion();
    w(OFS_MODE, 32'h0000_0000);
    chk_motion();
    w(OFS_MODE, 32'h0000_0005);
    w(OFS_REQUEST, 32'h0000_0000);
    w(OFS_REQUEST, 32'h0000_0101 << n);
    chk_motion();
    $display("test edge arming done");
    w(OFS_REQUEST, 32'h0000_0000);
    w(OFS_REQUEST, $urandom & 32'h0000_ffff);
    for (int i = 0; i < 11; i++) begin
      w(p_addr[i], (i == 8) ? ($urandom & 32'h0000_00ff) : p_data[i]);
      chk_motion();
    end
    w(OFS_MODE, 32'h0000_0005);
    chk_motion();
    $display("test permissives done");
    for (int i = 0; i < 2; i++) begin
      w(OFS_POS_ERR, 32'h0000_0015 - 32'(i));
      chk_status();
    end
    $display("test in-position done");
    finish_test();
  end
endmodule
